// *** src/rpc_pkg.sv ***
/*
 * Constants, field layouts and types for the reset and PLL configuration block.
 * Assumes one core clock (hclk, 200 MHz) and an AHB-Lite register bus.
 */
// Overview of operation
// - pre-divide factor equals field value plus one
// - range bit selects high or low VCO band
// - power-on: latch straps, reset PLL, drive pin
// - hard reset drives pin, keeps straps and PLL
// - soft reset from scan instructions, pin untouched
// - every reset source resets all units
// - five straps latched at power-on release
// - boot configuration from host port or memory
// - pin held 521 reference cycles after power-on
package rpc_pkg;
	// register map, byte addresses
	localparam logic [7:0] RPC_ADDR_CLOCK_CTRL = 8'h00;
	localparam logic [7:0] RPC_ADDR_STATUS     = 8'h04;
	// clock_control_reg layout
	localparam int RPC_PREDIV_LSB = 0;
	localparam int RPC_PREDIV_W   = 4;
	localparam int RPC_MULT_LSB   = 4;
	localparam int RPC_MULT_W     = 8;
	localparam int RPC_RANGE_BIT  = 12;
	localparam int RPC_CORE_CLOCK_SELECT_BIT  = 13;
	localparam logic [31:0] RPC_CLOCK_CTRL_RESET = 32'h0000_0000;
	localparam logic [3:0] RPC_PREDIV_MAX = 4'h8;
	// vco band edges in MHz
	localparam logic [9:0] RPC_VCO_HI_MIN = 10'h12c;
	localparam logic [9:0] RPC_VCO_HI_MAX = 10'h258;
	localparam logic [9:0] RPC_VCO_LO_MIN = 10'h096;
	localparam logic [9:0] RPC_VCO_LO_MAX = 10'h12c;
	// reference clock cycles the pin stays low after power-on release
	localparam logic [9:0] RPC_HOLD_REF_CYCLES = 10'h209;
	// scan instruction codes that raise soft reset
	localparam logic [3:0] RPC_SCAN_EXTEST = 4'h0;
	localparam logic [3:0] RPC_SCAN_CLAMP  = 4'h3;
	localparam logic [3:0] RPC_SCAN_HIGHZ  = 4'h4;
	// boot mode straps that select the serial memory source
	localparam logic [1:0] RPC_BOOT_MEMORY = 2'h0;
	// reset cause codes
	localparam logic [1:0] RPC_CAUSE_POWER = 2'h1;
	localparam logic [1:0] RPC_CAUSE_HARD  = 2'h2;
	localparam logic [1:0] RPC_CAUSE_SOFT  = 2'h3;

	typedef struct packed {
		logic [1:0] boot_mode_straps;
		logic       watchdog_enable_strap;
		logic       host_byte_width_strap;
		logic       host_strobe_polarity_strap;
	} rpc_straps_s;

	typedef enum logic [2:0] {
		RPC_SEQ_POWER = 3'b001,
		RPC_SEQ_HOLD  = 3'b010,
		RPC_SEQ_RUN   = 3'b100
	} rpc_seq_e;
endpackage

// *** src/rpc_reset_pll_config.sv ***
/*
 * Reset sequencer and PLL configuration register block.
 * Assumes pins are asynchronous, watchdog/bus monitor/scan inputs are on hclk,
 * and the reference clock is slow enough to be sampled by hclk.
 */
`timescale 1ns/1ps
module rpc_reset_pll_config
	import rpc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        power_on_reset_pin_n,
	input  wire logic        hard_reset_pin_in_n,
	output logic             hard_reset_pin_out,
	output logic             hard_reset_pin_oe,
	input  wire logic        reference_input_clock,
	input  wire rpc_straps_s strap_pins,
	input  wire logic        watchdog_expired,
	input  wire logic        bus_monitor_timeout,
	input  wire logic [3:0]  scan_instr,
	input  wire logic        scan_instr_valid,
	output rpc_straps_s      straps,
	output logic             boot_from_host,
	output logic             pll_reset,
	output logic [3:0]       pll_predivide_factor,
	output logic [7:0]       pll_multiply_field,
	output logic             vco_range_bit,
	output logic [9:0]       vco_band_min,
	output logic [9:0]       vco_band_max,
	output logic             core_clock_select,
	output logic             unit_reset,
	output logic             soft_reset
);
	logic [2:0]  por_sync;
	logic [1:0]  hard_sync;
	logic [2:0]  ref_sync;
	rpc_straps_s strap_s1;
	rpc_straps_s strap_s2;
	rpc_seq_e    seq_reg;
	logic [9:0]  hold_cnt_reg;
	logic [1:0]  oe_hist_reg;
	logic [31:0] clock_ctrl_reg;
	logic [1:0]  cause_reg;
	logic        prediv_err_reg;
	logic        addr_wr_reg;
	logic        addr_ctl_reg;
	logic        por_active;
	logic        ref_edge;
	logic        internal_hard;
	logic        external_hard;
	logic        soft_cmd;
	logic        strap_take;

	assign por_active    = ~por_sync[1];
	assign ref_edge      = ref_sync[1] & ~ref_sync[2];
	assign internal_hard = watchdog_expired | bus_monitor_timeout;
	// pin sense trails our own release by the synchroniser; masked until it has caught up
	assign external_hard = ~hard_sync[1] & ~hard_reset_pin_oe & ~oe_hist_reg[0] & ~oe_hist_reg[1];
	assign soft_cmd      = scan_instr_valid & ((scan_instr == RPC_SCAN_EXTEST) |
		(scan_instr == RPC_SCAN_CLAMP) | (scan_instr == RPC_SCAN_HIGHZ));
	assign strap_take    = (seq_reg == RPC_SEQ_POWER) & ~por_active;

	// two-flop synchronisers; stage 0 read only by stage 1
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			por_sync  <= 3'h0;
			hard_sync <= 2'h3;
			ref_sync  <= 3'h0;
			strap_s1  <= '0;
			strap_s2  <= '0;
		end
		else
		begin
			por_sync  <= {por_sync[1], por_sync[0], power_on_reset_pin_n};
			hard_sync <= {hard_sync[0], hard_reset_pin_in_n};
			ref_sync  <= {ref_sync[1], ref_sync[0], reference_input_clock};
			strap_s1  <= strap_pins;
			strap_s2  <= strap_s1;
		end
	end

	// reset sequencer: power-on wins over everything, internal or external hard while running starts a new hold
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			seq_reg      <= RPC_SEQ_POWER;
			hold_cnt_reg <= 10'h000;
		end
		else if (por_active)
		begin
			seq_reg      <= RPC_SEQ_POWER;
			hold_cnt_reg <= 10'h000;
		end
		else
		begin
			unique case (seq_reg)
				RPC_SEQ_POWER:
				begin
					seq_reg      <= RPC_SEQ_HOLD;
					hold_cnt_reg <= 10'h000;
				end
				RPC_SEQ_HOLD:
				begin
					if (ref_edge && hold_cnt_reg == RPC_HOLD_REF_CYCLES - 10'h001)
					begin
						seq_reg      <= RPC_SEQ_RUN;
						hold_cnt_reg <= 10'h000;
					end
					else if (ref_edge)
						hold_cnt_reg <= hold_cnt_reg + 10'h001;
				end
				RPC_SEQ_RUN:
				begin
					hold_cnt_reg <= 10'h000;
					// an external pull on the pin starts the same driven hold as an internal one
					if (internal_hard || external_hard)
						seq_reg <= RPC_SEQ_HOLD;
				end
			endcase
		end
	end

	// open-drain hard reset pin, pulled low while not running
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hard_reset_pin_oe  <= 1'b1;
			hard_reset_pin_out <= 1'b0;
			oe_hist_reg        <= 2'h3;
		end
		else
		begin
			hard_reset_pin_oe  <= por_active | (seq_reg != RPC_SEQ_RUN) | internal_hard;
			hard_reset_pin_out <= 1'b0;
			oe_hist_reg        <= {oe_hist_reg[0], hard_reset_pin_oe};
		end
	end

	// unit resets; soft reset never touches the pin or the PLL
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pll_reset  <= 1'b1;
			unit_reset <= 1'b1;
			soft_reset <= 1'b0;
			cause_reg  <= RPC_CAUSE_POWER;
		end
		else
		begin
			pll_reset  <= por_active;
			unit_reset <= por_active | (seq_reg != RPC_SEQ_RUN) | internal_hard | external_hard | soft_cmd;
			soft_reset <= soft_cmd;
			if (por_active)
				cause_reg <= RPC_CAUSE_POWER;
			else if (internal_hard || external_hard)
				cause_reg <= RPC_CAUSE_HARD;
			else if (soft_cmd)
				cause_reg <= RPC_CAUSE_SOFT;
		end
	end

	// straps caught once at power-on release, untouched by hard or soft reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			straps <= '0;
		else if (strap_take)
			straps <= strap_s2;
	end

	// boot source follows latched mode straps
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			boot_from_host <= 1'b0;
		else
			boot_from_host <= (straps.boot_mode_straps != RPC_BOOT_MEMORY);
	end

	// ahb-lite address phase capture; zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_wr_reg  <= 1'b0;
			addr_ctl_reg <= 1'b0;
			hrdata       <= 32'h0000_0000;
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
		end
		else
		begin
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			addr_wr_reg  <= hsel & hready & htrans[1] & hwrite;
			addr_ctl_reg <= (haddr[7:0] == RPC_ADDR_CLOCK_CTRL) & (haddr[31:8] == 24'h000000);
			if (hsel && hready && htrans[1] && !hwrite)
			begin
				if (haddr[31:8] != 24'h000000)
					hrdata <= 32'h0000_0000;
				else if (haddr[7:0] == RPC_ADDR_CLOCK_CTRL)
					hrdata <= clock_ctrl_reg;
				else if (haddr[7:0] == RPC_ADDR_STATUS)
					hrdata <= {22'h0, (seq_reg != RPC_SEQ_RUN), prediv_err_reg,
						cause_reg, boot_from_host, straps};
				else
					hrdata <= 32'h0000_0000;
			end
		end
	end

	// clock control: only power-on clears it, hard and soft keep PLL settings
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			clock_ctrl_reg <= RPC_CLOCK_CTRL_RESET;
		else if (por_active)
			clock_ctrl_reg <= RPC_CLOCK_CTRL_RESET;
		else if (addr_wr_reg && addr_ctl_reg)
			clock_ctrl_reg <= {18'h00000, hwdata[13:0]};
	end

	// PLL settings to the synthesiser; band limits follow the range bit
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pll_predivide_factor <= 4'h1;
			pll_multiply_field   <= 8'h00;
			vco_range_bit        <= 1'b0;
			core_clock_select    <= 1'b0;
			vco_band_min         <= RPC_VCO_LO_MIN;
			vco_band_max         <= RPC_VCO_LO_MAX;
			prediv_err_reg       <= 1'b0;
		end
		else
		begin
			pll_predivide_factor <= clock_ctrl_reg[RPC_PREDIV_LSB +: RPC_PREDIV_W] + 4'h1;
			pll_multiply_field   <= clock_ctrl_reg[RPC_MULT_LSB +: RPC_MULT_W];
			vco_range_bit        <= clock_ctrl_reg[RPC_RANGE_BIT];
			core_clock_select    <= clock_ctrl_reg[RPC_CORE_CLOCK_SELECT_BIT];
			vco_band_min         <= clock_ctrl_reg[RPC_RANGE_BIT] ? RPC_VCO_HI_MIN : RPC_VCO_LO_MIN;
			vco_band_max         <= clock_ctrl_reg[RPC_RANGE_BIT] ? RPC_VCO_HI_MAX : RPC_VCO_LO_MAX;
			prediv_err_reg       <= clock_ctrl_reg[RPC_PREDIV_LSB +: RPC_PREDIV_W] > RPC_PREDIV_MAX;
		end
	end

	// checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_divide_factor: assert property ($past(clock_ctrl_reg[3:0]) <= RPC_PREDIV_MAX |->
		pll_predivide_factor == $past(clock_ctrl_reg[3:0]) + 4'h1) else $error("divide factor wrong");
	a_vco_band: assert property (vco_range_bit |->
		vco_band_min == RPC_VCO_HI_MIN && vco_band_max == RPC_VCO_HI_MAX) else $error("vco band wrong");
	a_power_pll_pin: assert property (por_active |=> pll_reset && hard_reset_pin_oe && unit_reset)
		else $error("power-on did not reset pll or drive pin");
	a_hard_keeps_pll: assert property (seq_reg == RPC_SEQ_RUN && internal_hard && !por_active |=>
		hard_reset_pin_oe && !pll_reset && $stable(straps)) else $error("hard reset disturbed pll or straps");
	a_ext_hard_hold: assert property (seq_reg == RPC_SEQ_RUN && external_hard && !por_active |=>
		seq_reg == RPC_SEQ_HOLD) else $error("external hard reset ignored");
	a_soft_no_pin: assert property (seq_reg == RPC_SEQ_RUN && soft_cmd && !internal_hard && !por_active |=>
		soft_reset && unit_reset && !hard_reset_pin_oe && !pll_reset) else $error("soft reset wrong");
	a_all_reset_units: assert property (soft_reset || pll_reset |-> unit_reset)
		else $error("unit reset missing");
	a_strap_latch: assert property (strap_take |=> straps == $past(strap_s2))
		else $error("straps not latched");
	a_strap_hold: assert property (!strap_take |=> $stable(straps)) else $error("straps changed");
	a_boot_source: assert property (##1 boot_from_host == ($past(straps.boot_mode_straps) != RPC_BOOT_MEMORY))
		else $error("boot source wrong");
	a_hold_count: assert property (seq_reg == RPC_SEQ_HOLD && !por_active && ref_edge &&
		hold_cnt_reg == RPC_HOLD_REF_CYCLES - 10'h001 |=> seq_reg == RPC_SEQ_RUN) else $error("hold not ended");
	a_hold_bound: assert property (hold_cnt_reg < RPC_HOLD_REF_CYCLES) else $error("hold counter overran");
endmodule

// *** dv/rpc_board_model.sv ***
/*
 * Board-side model: reset supervisor, strap source, reference clock.
 * Assumes the bench asks for power-on cycles and external hard resets.
 */
`timescale 1ns/1ps
module rpc_board_model
	import rpc_pkg::*;
(
	input  wire logic        por_req,
	input  wire logic        ext_hard_req,
	input  wire rpc_straps_s strap_value,
	input  wire logic        hard_reset_pin_oe,
	output logic             power_on_reset_pin_n,
	output logic             hard_reset_pin_in_n,
	output logic             reference_input_clock,
	output rpc_straps_s      strap_pins
);
	int hold = 20;

	// 25 MHz reference, far below the input ceiling
	initial
	begin
		reference_input_clock = 1'b0;
		forever #20 reference_input_clock = ~reference_input_clock;
	end

	// power-on held 20 reference cycles, straps steady 8 cycles past release
	always @(posedge reference_input_clock or posedge por_req)
		if (por_req)
			hold <= 20;
		else if (hold > -8)
			hold <= hold - 1;
	assign power_on_reset_pin_n = (hold <= 0);
	// straps go inverted once their hold has run out, no kinder than a board
	assign strap_pins = (hold > -8) ? strap_value : ~strap_value;
	// open-drain pin with pull-up
	assign hard_reset_pin_in_n = ~(hard_reset_pin_oe | ext_hard_req);
endmodule

// *** dv/tb_reset_and_pll_config.sv ***
/*
 * Self-checking bench for the reset and pll configuration block.
 * Assumes rpc_board_model on the pins and the rpc_pkg constants.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_reset_and_pll_config
	import rpc_pkg::*;
;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, wd_exp, bus_to, scan_valid;
	logic        por_req, ext_hard, pin_n, hpin_n, hpin_out, hpin_oe, ref_clk, pll_reset, vco_range;
	logic        ccs, unit_reset, soft_reset, boot_host;
	logic [31:0] haddr, hwdata, hrdata, rd, rnd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  scan_instr, pdf;
	logic [7:0]  mult;
	logic [9:0]  bmin, bmax;
	logic [13:0] m_ctrl;
	rpc_straps_s strap_val, strap_pins, straps, m_straps;
	int          failures = 0, checks_done = 0, cyc = 0, seed = 32'h6669d03f;
	logic [3:0]  codes [4] = '{4'h0, 4'h3, 4'h4, 4'h1};

	assign hready = hreadyout;
	rpc_reset_pll_config dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .power_on_reset_pin_n(pin_n), .hard_reset_pin_in_n(hpin_n),
		.hard_reset_pin_out(hpin_out), .hard_reset_pin_oe(hpin_oe), .reference_input_clock(ref_clk),
		.strap_pins(strap_pins), .watchdog_expired(wd_exp), .bus_monitor_timeout(bus_to),
		.scan_instr(scan_instr), .scan_instr_valid(scan_valid), .straps(straps), .boot_from_host(boot_host),
		.pll_reset(pll_reset), .pll_predivide_factor(pdf), .pll_multiply_field(mult), .vco_range_bit(vco_range),
		.vco_band_min(bmin), .vco_band_max(bmax), .core_clock_select(ccs), .unit_reset(unit_reset),
		.soft_reset(soft_reset));
	rpc_board_model board (.por_req(por_req), .ext_hard_req(ext_hard), .strap_value(strap_val),
		.hard_reset_pin_oe(hpin_oe), .power_on_reset_pin_n(pin_n), .hard_reset_pin_in_n(hpin_n),
		.reference_input_clock(ref_clk), .strap_pins(strap_pins));

	task automatic finish_test();
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// single word transfer; waits for hready, no assumed latency
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic check_cfg();
		repeat (2) @(posedge hclk);
		ahb(1'b0, RPC_ADDR_CLOCK_CTRL, 32'h0);
		`CHK(rd, {18'h00000, m_ctrl})
		`CHK(pdf, m_ctrl[3:0] + 4'h1)
		`CHK({ccs, vco_range, mult}, m_ctrl[13:4])
		`CHK(bmin, m_ctrl[12] ? 10'h12c : 10'h096)
		`CHK(bmax, m_ctrl[12] ? 10'h258 : 10'h12c)
		`CHK({hresp, hpin_out}, 2'b00)
	endtask

	task automatic check_straps(input logic [1:0] cause);
		ahb(1'b0, RPC_ADDR_STATUS, 32'h0);
		`CHK(straps, m_straps)
		`CHK(boot_host, m_straps.boot_mode_straps != RPC_BOOT_MEMORY)
		`CHK(rd[7:0], {cause, m_straps.boot_mode_straps != RPC_BOOT_MEMORY, m_straps})
		`CHK(rd[9:8], {1'b0, m_ctrl[3:0] > 4'h8})
	endtask

	// full power-on cycle; counts reference edges until the pin is let go
	task automatic power_on();
		int n;
		n = 0;
		rnd = $random(seed);
		strap_val <= rnd[4:0];
		por_req   <= 1'b1;
		@(posedge hclk);
		por_req  <= 1'b0;
		m_straps = rnd[4:0];
		m_ctrl   = 14'h0000;
		repeat (4) @(posedge hclk);
		`CHK({hpin_oe, pll_reset, unit_reset}, 3'b111)
		wait (pin_n === 1'b1);
		while (hpin_oe === 1'b1)
		begin
			@(posedge ref_clk);
			n++;
		end
		`CHK(n, 522)
		@(posedge hclk);
		check_cfg();
		check_straps(RPC_CAUSE_POWER);
	endtask

	// 200 MHz clock
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// hang guard, well above the five reset cycles of the run
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			failures++;
			finish_test();
		end
	end

	initial
	begin
		{hresetn, hsel, hwrite, wd_exp, bus_to, scan_valid, por_req, ext_hard} = 8'h00;
		{htrans, haddr, hwdata, hsize, scan_instr, strap_val} = {2'h0, 64'h0, 3'h2, 4'h0, 5'h00};
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		power_on();
		// every legal pre-divide code plus the first flagged one, random upper fields, both vco ranges
		for (int p = 0; p < 10; p++)
		begin
			rnd    = $random(seed);
			m_ctrl = {rnd[13], p[0], rnd[11:4], p[3:0]};
			ahb(1'b1, RPC_ADDR_CLOCK_CTRL, {rnd[31:14], m_ctrl});
			check_cfg();
			check_straps(RPC_CAUSE_POWER);
		end
		// legal setup for the 25 MHz reference: 12.5 MHz into the multiplier, 400 MHz out
		m_ctrl = {1'b0, 1'b1, 8'h1f, 4'h1};
		ahb(1'b1, RPC_ADDR_CLOCK_CTRL, {18'h00000, m_ctrl});
		check_cfg();
		ahb(1'b0, 8'h08, 32'h0);
		`CHK(rd, 32'h00000000)
		// watchdog, bus monitor, external pin: pin driven, pll kept
		for (int k = 0; k < 3; k++)
		begin
			wd_exp   <= (k == 0);
			bus_to   <= (k == 1);
			ext_hard <= (k == 2);
			@(posedge hclk);
			wd_exp <= 1'b0;
			bus_to <= 1'b0;
			while (hpin_oe !== 1'b1) @(posedge hclk);
			ext_hard <= 1'b0;
			@(posedge hclk);
			`CHK({unit_reset, pll_reset, soft_reset}, 3'b100)
			while (hpin_oe === 1'b1) @(posedge hclk);
			check_cfg();
			check_straps(RPC_CAUSE_HARD);
		end
		// scan codes; the last is not a reset instruction
		foreach (codes[i])
		begin
			scan_instr <= codes[i];
			scan_valid <= 1'b1;
			repeat (3) @(posedge hclk);
			`CHK({soft_reset, unit_reset, hpin_oe, pll_reset}, {i < 3, i < 3, 2'b00})
			scan_valid <= 1'b0;
			repeat (3) @(posedge hclk);
			`CHK(soft_reset, 1'b0)
			check_straps(RPC_CAUSE_SOFT);
		end
		check_cfg();
		power_on();
		finish_test();
	end
endmodule
